// ==== core/stack_addr_pkg.sv ====
/*
 Constants shared by the stack pointer and operand-address logic of a 16-bit core.
 Assumes a byte-addressed 16-bit data space and a 23-bit program counter.
*/
package stack_addr_pkg;
   localparam int          DATA_W       = 16;
   localparam int          PC_W         = 23;
   localparam int          DIRECT_W     = 13;
   localparam int          LIT_W        = 5;
   localparam int          LIT10_W      = 10;
   localparam logic [15:0] SP_RESET     = 16'h1000;
   localparam logic [15:0] WORD_STEP    = 16'h0002;
   localparam logic [15:0] BYTE_STEP    = 16'h0001;
   localparam logic [15:0] NEAR_LIMIT   = 16'h1FFF;
   localparam logic [3:0]  REG_ZERO     = 4'h0;
   localparam logic [3:0]  REG_FRAME    = 4'hE;
   localparam logic [3:0]  REG_STACK    = 4'hF;
   localparam int          NUM_REGS     = 16;

   // Operand addressing modes.
   typedef enum logic [2:0] {
      MODE_DIRECT   = 3'h0,
      MODE_INDIRECT = 3'h1,
      MODE_POST_INC = 3'h3,
      MODE_POST_DEC = 3'h2,
      MODE_PRE_INC  = 3'h6,
      MODE_PRE_DEC  = 3'h7,
      MODE_LIT5     = 3'h5,
      MODE_LIT10    = 3'h4
   } addr_mode_e;

   // Stack sequencer states, Gray coded along the two-word save only; return jumps from 00 to 11.
   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_WORD1 = 2'b01,
      ST_WORD2 = 2'b11
   } stack_state_e;
endpackage : stack_addr_pkg

// ==== core/stack_addr_unit.sv ====
/*
 Stack pointer and operand effective-address unit of a 16-bit core.
 Assumes the core presents one request per cycle while o_busy is low, and that
 memory accepts the address and data driven on the stack and operand ports.
*/
`timescale 1ns/1ps
`default_nettype none
module stack_addr_unit
   import stack_addr_pkg::*;
(
   input  wire logic              i_sys_clk,      // Core clock, 100 MHz.
   input  wire logic              i_resetn,       // Any device reset, low.
   input  wire logic              i_sp_wr,        // Software write of stack pointer.
   input  wire logic [15:0]       i_sp_wdata,     // Value written.
   input  wire logic              i_fp_wr,        // Software write of frame pointer.
   input  wire logic [15:0]       i_fp_wdata,     // Value written.
   input  wire logic              i_frame_pointer_active, // Frame pointer in stack use.
   input  wire logic              i_push,         // Push one data word.
   input  wire logic              i_pop,          // Pop one data word.
   input  wire logic [15:0]       i_push_data,    // Word to push.
   input  wire logic              i_call,         // Save PC for a call.
   input  wire logic              i_exception,    // Save PC for an exception.
   input  wire logic              i_return,       // Remove a two-word PC frame.
   input  wire logic [PC_W-1:0]   i_pc,           // Program counter to save.
   input  wire logic [7:0]        i_status_low_byte, // Low byte of cpu_status_reg.
   input  wire logic              i_op_req,       // Operand address request.
   input  wire logic              i_op_file,      // File-register form.
   input  wire logic              i_op_move,      // Move with full 16-bit address.
   input  wire logic [15:0]       i_op_field,     // Direct address or literal.
   input  wire logic [3:0]        i_base_reg,     // base_operand_reg index.
   input  wire logic [3:0]        i_src_reg,      // Second operand register.
   input  wire logic [2:0]        i_mode,         // Second operand addressing mode.
   input  wire logic              i_byte_op,      // Byte operation, step of one.
   input  wire logic              i_reg_wr,       // Write a working register.
   input  wire logic [3:0]        i_reg_waddr,    // Its index.
   input  wire logic [15:0]       i_reg_wdata,    // Its value.
   output logic [15:0]            o_soft_stack_pointer, // Current stack pointer.
   output logic [15:0]            o_frame_pointer_reg,  // Current frame pointer.
   output logic                   o_stk_we,       // Stack write strobe.
   output logic                   o_stk_re,       // Stack read strobe.
   output logic [15:0]            o_stk_addr,     // Unpaged stack address.
   output logic [15:0]            o_stk_wdata,    // Stack write data.
   output logic                   o_busy,         // Two-word save or return in progress.
   output logic                   o_op_valid,     // Operand address valid.
   output logic [15:0]            o_op_addr,      // Effective address.
   output logic                   o_op_is_lit,    // Operand is a literal.
   output logic [15:0]            o_op_lit,       // Zero-extended literal.
   output logic                   o_op_unpaged,   // Address bypasses paging.
   output logic [3:0]             o_base_operand_reg, // Operand 1 register.
   output logic [3:0]             o_dest_reg      // Default destination.
);
   typedef struct packed {
      stack_state_e state;
      logic [15:0]  sp;
      logic [15:0]  fp;
      logic [15:0]  hi_word;
      logic         stk_we;
      logic         stk_re;
      logic [15:0]  stk_addr;
      logic [15:0]  stk_wdata;
      logic         busy;
      logic         op_valid;
      logic [15:0]  op_addr;
      logic         op_is_lit;
      logic [15:0]  op_lit;
      logic         op_unpaged;
      logic [3:0]   base;
      logic [3:0]   dest;
      logic         pend_update;
      logic [3:0]   upd_reg;
      logic [15:0]  upd_val;
   } state_s;

   state_s st_r;
   state_s st_nxt;

   logic [15:0] reg_rdata;
   logic [15:0] step;
   logic [15:0] ptr;
   logic        rf_we;
   logic [3:0]  rf_waddr;
   logic [15:0] rf_wdata;

   // Pending indirect pointer updates have priority over a core write.
   assign rf_we    = st_r.pend_update | i_reg_wr;
   assign rf_waddr = st_r.pend_update ? st_r.upd_reg : i_reg_waddr;
   assign rf_wdata = st_r.pend_update ? st_r.upd_val : i_reg_wdata;

   work_reg_file #(.WIDTH(DATA_W), .DEPTH(NUM_REGS)) u_regs (
      .i_sys_clk (i_sys_clk),
      .i_resetn  (i_resetn),
      .i_we      (rf_we),
      .i_waddr   (rf_waddr),
      .i_wdata   (rf_wdata),
      .i_raddr   (i_src_reg),
      .o_rdata   (reg_rdata)
   );

   assign step = i_byte_op ? BYTE_STEP : WORD_STEP;
   // Stack and frame pointers live here; other registers come from the file.
   assign ptr  = (i_src_reg == REG_STACK) ? st_r.sp :
                 (i_src_reg == REG_FRAME) ? st_r.fp : reg_rdata;

   // Next-state logic for stack sequencing and operand address generation.
   always_comb begin
      st_nxt             = st_r;
      st_nxt.stk_we      = 1'b0;
      st_nxt.stk_re      = 1'b0;
      st_nxt.op_valid    = 1'b0;
      st_nxt.pend_update = 1'b0;
      case (st_r.state)
         ST_IDLE: begin
            if (i_call || i_exception) begin
               st_nxt.stk_we    = 1'b1;
               st_nxt.stk_addr  = st_r.sp;
               st_nxt.stk_wdata = i_pc[15:0];
               // Call pads with zeros, exception keeps the status low byte.
               st_nxt.hi_word   = i_exception ? {i_status_low_byte, 1'b0, i_pc[22:16]}
                                              : {8'h00, 1'b0, i_pc[22:16]};
               st_nxt.sp        = st_r.sp + WORD_STEP;
               st_nxt.busy      = 1'b1;
               st_nxt.state     = ST_WORD1;
            end else if (i_return) begin
               st_nxt.sp     = st_r.sp - WORD_STEP;
               st_nxt.stk_re = 1'b1;
               st_nxt.stk_addr = st_r.sp - WORD_STEP;
               st_nxt.busy   = 1'b1;
               st_nxt.state  = ST_WORD2;
            end else if (i_push) begin
               st_nxt.stk_we    = 1'b1;
               st_nxt.stk_addr  = st_r.sp;
               st_nxt.stk_wdata = i_push_data;
               st_nxt.sp        = st_r.sp + WORD_STEP;
            end else if (i_pop) begin
               st_nxt.sp       = st_r.sp - WORD_STEP;
               st_nxt.stk_re   = 1'b1;
               st_nxt.stk_addr = st_r.sp - WORD_STEP;
            end else if (i_sp_wr) begin
               st_nxt.sp = {i_sp_wdata[15:1], 1'b0};
            end
            if (i_fp_wr) begin
               st_nxt.fp = i_fp_wdata;
            end
         end
         ST_WORD1: begin
            st_nxt.stk_we    = 1'b1;
            st_nxt.stk_addr  = st_r.sp;
            st_nxt.stk_wdata = st_r.hi_word;
            st_nxt.sp        = st_r.sp + WORD_STEP;
            st_nxt.busy      = 1'b0;
            st_nxt.state     = ST_IDLE;
         end
         ST_WORD2: begin
            st_nxt.sp       = st_r.sp - WORD_STEP;
            st_nxt.stk_re   = 1'b1;
            st_nxt.stk_addr = st_r.sp - WORD_STEP;
            st_nxt.busy     = 1'b0;
            st_nxt.state    = ST_IDLE;
         end
         default: begin
            st_nxt.state = ST_IDLE;
            st_nxt.busy  = 1'b0;
         end
      endcase

      // Operand address; the register file read lags one cycle, so the
      // request registers with the previous cycle's read index held stable.
      if (i_op_req) begin
         st_nxt.op_valid   = 1'b1;
         st_nxt.op_is_lit  = 1'b0;
         st_nxt.op_lit     = 16'h0000;
         st_nxt.base       = i_base_reg;
         st_nxt.dest       = REG_ZERO;
         st_nxt.op_unpaged = (i_src_reg == REG_STACK) ||
                             ((i_src_reg == REG_FRAME) && i_frame_pointer_active);
         if (i_op_file) begin
            st_nxt.op_addr = {3'b000, i_op_field[DIRECT_W-1:0]};
         end else if (i_op_move) begin
            st_nxt.op_addr = i_op_field;
         end else begin
            case (i_mode)
               MODE_DIRECT, MODE_INDIRECT: st_nxt.op_addr = ptr;
               MODE_POST_INC: begin
                  st_nxt.op_addr = ptr;
                  st_nxt.pend_update = 1'b1;
                  st_nxt.upd_val = ptr + step;
               end
               MODE_POST_DEC: begin
                  st_nxt.op_addr = ptr;
                  st_nxt.pend_update = 1'b1;
                  st_nxt.upd_val = ptr - step;
               end
               MODE_PRE_INC: begin
                  st_nxt.op_addr = ptr + step;
                  st_nxt.pend_update = 1'b1;
                  st_nxt.upd_val = ptr + step;
               end
               MODE_PRE_DEC: begin
                  st_nxt.op_addr = ptr - step;
                  st_nxt.pend_update = 1'b1;
                  st_nxt.upd_val = ptr - step;
               end
               MODE_LIT5: begin
                  st_nxt.op_is_lit = 1'b1;
                  st_nxt.op_lit = {11'h000, i_op_field[LIT_W-1:0]};
                  st_nxt.op_addr = 16'h0000;
               end
               MODE_LIT10: begin
                  st_nxt.op_is_lit = 1'b1;
                  st_nxt.op_lit = {6'h00, i_op_field[LIT10_W-1:0]};
                  st_nxt.op_addr = 16'h0000;
               end
               default: st_nxt.op_addr = ptr;
            endcase
            st_nxt.upd_reg = i_src_reg;
            // Stack and frame pointers are not held in the file, so they take the
            // modified value here; otherwise indirect modes could not move them.
            if (st_nxt.pend_update && i_src_reg == REG_STACK) begin
               st_nxt.sp = st_nxt.upd_val;
            end
            if (st_nxt.pend_update && i_src_reg == REG_FRAME) begin
               st_nxt.fp = st_nxt.upd_val;
            end
            if (i_src_reg == REG_STACK || i_src_reg == REG_FRAME) begin
               st_nxt.pend_update = 1'b0;
            end
         end
      end
      st_nxt.sp[0] = 1'b0;
   end

   // Single state register; reset restores the stack pointer for early traps.
   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         st_r       <= '0;
         st_r.state <= ST_IDLE;
         st_r.sp    <= SP_RESET;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign o_soft_stack_pointer = st_r.sp;
   assign o_frame_pointer_reg  = st_r.fp;
   assign o_stk_we             = st_r.stk_we;
   assign o_stk_re             = st_r.stk_re;
   assign o_stk_addr           = st_r.stk_addr;
   assign o_stk_wdata          = st_r.stk_wdata;
   assign o_busy               = st_r.busy;
   assign o_op_valid           = st_r.op_valid;
   assign o_op_addr            = st_r.op_addr;
   assign o_op_is_lit          = st_r.op_is_lit;
   assign o_op_lit             = st_r.op_lit;
   assign o_op_unpaged         = st_r.op_unpaged;
   assign o_base_operand_reg   = st_r.base;
   assign o_dest_reg           = st_r.dest;
endmodule : stack_addr_unit
`default_nettype wire

// ==== core/work_reg_file.sv ====
/*
 Sixteen-entry working register file with registered read data.
 Assumes writes and reads are issued by the owning sequencer on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module work_reg_file
   import stack_addr_pkg::*;
#(
   parameter int WIDTH = DATA_W,
   parameter int DEPTH = NUM_REGS
) (
   input  wire logic                     i_sys_clk,   // Core clock.
   input  wire logic                     i_resetn,    // Asynchronous reset, low.
   input  wire logic                     i_we,        // Write strobe.
   input  wire logic [$clog2(DEPTH)-1:0] i_waddr,     // Write index.
   input  wire logic [WIDTH-1:0]         i_wdata,     // Write data.
   input  wire logic [$clog2(DEPTH)-1:0] i_raddr,     // Read index.
   output logic      [WIDTH-1:0]         o_rdata      // Registered read data.
);
   initial begin
      if (DEPTH < 2) $error("work_reg_file needs at least two entries");
   end

   logic [WIDTH-1:0] mem_r [DEPTH];

   // Storage has no reset; the sequencer owns initial values it cares about.
   always_ff @(posedge i_sys_clk) begin
      if (i_we) begin
         mem_r[i_waddr] <= i_wdata;
      end
   end

   // Read data comes from a register so the read path has one clean stage.
   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_rdata <= '0;
      end else begin
         o_rdata <= mem_r[i_raddr];
      end
   end
endmodule : work_reg_file
`default_nettype wire

// ==== testbench/stack_addr_unit_chk.sv ====
/*
 Concurrent checks on the stack and operand ports of stack_addr_unit.
 Assumes it is bound to that module and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
module stack_addr_chk
   import stack_addr_pkg::*;
(
   input wire logic            i_sys_clk,            // Core clock.
   input wire logic            i_resetn,             // Reset, low.
   input wire logic            i_sp_wr,              // Pointer write.
   input wire logic [15:0]     i_sp_wdata,           // Pointer value.
   input wire logic            i_push,               // Push request.
   input wire logic            i_pop,                // Pop request.
   input wire logic [15:0]     i_push_data,          // Pushed word.
   input wire logic            i_call,               // Call save.
   input wire logic            i_exception,          // Exception save.
   input wire logic            i_return,             // Return.
   input wire logic [PC_W-1:0] i_pc,                 // Program counter.
   input wire logic [7:0]      i_status_low_byte,    // Status low byte.
   input wire logic            i_op_req,             // Operand request.
   input wire logic            i_op_file,            // File form.
   input wire logic            i_op_move,            // Move form.
   input wire logic [15:0]     i_op_field,           // Address field.
   input wire logic [3:0]      i_src_reg,            // Second operand register.
   input wire logic            i_frame_pointer_active, // Frame pointer in stack use.
   input wire logic [15:0]     o_soft_stack_pointer, // Stack pointer.
   input wire logic            o_stk_we,             // Stack write.
   input wire logic            o_stk_re,             // Stack read.
   input wire logic [15:0]     o_stk_addr,           // Stack address.
   input wire logic [15:0]     o_stk_wdata,          // Stack data.
   input wire logic            o_busy,               // Two-word save or return.
   input wire logic            o_op_valid,           // Operand valid.
   input wire logic [15:0]     o_op_addr,            // Effective address.
   input wire logic            o_op_unpaged,         // Address bypasses paging.
   input wire logic [3:0]      o_dest_reg            // Default destination.
);
   logic       no_frame;
   logic [15:0] pc_lo;
   logic [6:0]  pc_hi;

   // Helpers that keep the properties short; a frame request outranks data moves.
   assign no_frame = !(i_call | i_exception | i_return | o_busy);
   assign pc_lo    = i_pc[15:0];
   assign pc_hi    = i_pc[22:16];

   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_resetn);

   a_reset_sp_value:
      assert property ($rose(i_resetn) |-> o_soft_stack_pointer == SP_RESET)
      else $error("stack pointer not at reset value");
   a_sp_word_aligned:
      assert property (o_soft_stack_pointer[0] == 1'b0) else $error("stack pointer odd");
   a_push_write_inc:
      assert property (i_push && no_frame |=> o_stk_we && o_stk_addr == $past(o_soft_stack_pointer)
         && o_stk_wdata == $past(i_push_data)
         && o_soft_stack_pointer == $past(o_soft_stack_pointer) + 16'h0002)
      else $error("push wrong");
   a_pop_dec_read:
      assert property (i_pop && !i_push && no_frame |=> o_stk_re
         && o_stk_addr == $past(o_soft_stack_pointer) - 16'h0002
         && o_soft_stack_pointer == o_stk_addr) else $error("pop wrong");
   a_call_two_words:
      assert property (i_call && !i_exception && !o_busy |=> o_stk_we && o_busy
         && o_stk_addr == $past(o_soft_stack_pointer) && o_stk_wdata == $past(pc_lo)
         ##1 o_stk_we && !o_busy && o_stk_wdata == {9'h000, $past(pc_hi, 2)}
         && o_stk_addr == $past(o_soft_stack_pointer, 2) + 16'h0002
         && o_soft_stack_pointer == $past(o_soft_stack_pointer, 2) + 16'h0004)
      else $error("call frame wrong");
   a_exc_status_merge:
      assert property (i_exception && !i_call && !o_busy |=> ##1 o_stk_we
         && o_stk_wdata == {$past(i_status_low_byte, 2), 1'h0, $past(pc_hi, 2)})
      else $error("exception frame wrong");
   a_sp_sw_write:
      assert property (i_sp_wr && !i_push && !i_pop && no_frame
         |=> o_soft_stack_pointer == ($past(i_sp_wdata) & 16'hFFFE))
      else $error("pointer write wrong");
   a_file_direct_field:
      assert property (i_op_req && i_op_file && !i_op_move
         |=> o_op_valid && o_op_addr == ($past(i_op_field) & 16'h1FFF))
      else $error("direct field wrong");
   a_move_full_range:
      assert property (i_op_req && i_op_move && !i_op_file
         |=> o_op_valid && o_op_addr == $past(i_op_field)) else $error("move address wrong");
   a_dest_reg_zero:
      assert property (o_dest_reg == REG_ZERO) else $error("destination not zero");
   a_return_two_reads:
      assert property (i_return && !i_call && !i_exception && !o_busy
         |=> o_stk_re && o_busy && o_stk_addr == $past(o_soft_stack_pointer) - 16'h0002
         ##1 o_stk_re && !o_busy
         && o_stk_addr == $past(o_soft_stack_pointer, 2) - 16'h0004
         && o_soft_stack_pointer == o_stk_addr)
      else $error("return frame wrong");
   a_stack_unpaged:
      assert property (i_op_req |=> o_op_unpaged == $past(i_src_reg == REG_STACK
         || (i_src_reg == REG_FRAME && i_frame_pointer_active)))
      else $error("stack operand paging wrong");
endmodule : stack_addr_chk

bind stack_addr_unit stack_addr_chk stack_addr_chk_inst (.*);
`default_nettype wire

// ==== testbench/test_cpu_stack_and_operand_addressing.sv ====
/*
 Self-checking bench for the stack and operand-address unit.
 Assumes the package and design are compiled first; inputs move on falling edges.
*/
`timescale 1ns/1ps
`default_nettype none
module test_cpu_stack_and_operand_addressing
   import stack_addr_pkg::*;
;
   logic            i_sys_clk = 1'b0, i_resetn = 1'b0;
   logic            i_sp_wr, i_fp_wr, i_frame_pointer_active, i_push, i_pop, i_call;
   logic            i_exception, i_return, i_op_req, i_op_file, i_op_move, i_byte_op, i_reg_wr;
   logic [15:0]     i_sp_wdata, i_fp_wdata, i_push_data, i_op_field, i_reg_wdata;
   logic [PC_W-1:0] i_pc;
   logic [7:0]      i_status_low_byte;
   logic [3:0]      i_base_reg, i_src_reg, i_reg_waddr, o_base_operand_reg, o_dest_reg;
   logic [2:0]      i_mode;
   logic [15:0]     o_soft_stack_pointer, o_frame_pointer_reg, o_stk_addr, o_stk_wdata;
   logic [15:0]     o_op_addr, o_op_lit;
   logic            o_stk_we, o_stk_re, o_busy, o_op_valid, o_op_is_lit, o_op_unpaged;
   int              failures = 0, tests_run = 0;

   stack_addr_unit stack_addr_unit_inst (.*);

   // Free-running 100 MHz core clock.
   always #5 i_sys_clk = ~i_sys_clk;

   task automatic check(input string nm, input logic [39:0] seen, exp);
      tests_run++;
      if (seen !== exp) begin
         failures++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check

   task automatic step(input int n = 1);
      repeat (n) @(negedge i_sys_clk);
   endtask : step

   task automatic results;
      if (failures == 0 && tests_run > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : results

   // Two pushes back to back, then one pop of the last word.
   task automatic t_push_pop;
      i_push = 1'b1;
      i_push_data = 16'hA55A;
      step();
      check("push_we", o_stk_we, 1'b1);
      check("push_addr", o_stk_addr, SP_RESET);
      check("push_data", o_stk_wdata, 16'hA55A);
      i_push_data = 16'h5AA5;
      step();
      check("push2_addr", o_stk_addr, 16'h1002);
      i_push = 1'b0;
      i_pop = 1'b1;
      step();
      i_pop = 1'b0;
      check("pop_re", o_stk_re, 1'b1);
      check("pop_addr", o_stk_addr, 16'h1002);
      step();
      check("pop_sp", o_soft_stack_pointer, 16'h1002);
      check("pop_re_off", o_stk_re, 1'b0);
   endtask : t_push_pop

   // An odd software value lands word aligned.
   task automatic t_sp_write;
      i_sp_wr = 1'b1;
      i_sp_wdata = 16'h2345;
      step();
      i_sp_wr = 1'b0;
      check("sp_write", o_soft_stack_pointer, 16'h2344);
   endtask : t_sp_write

   // Call, with a push offered while busy that must be ignored.
   task automatic t_call;
      i_pc = 23'h5A1234;
      i_call = 1'b1;
      step();
      i_call = 1'b0;
      i_push = 1'b1;
      check("call_w1", {o_busy, o_stk_addr, o_stk_wdata}, {1'b1, 16'h2344, 16'h1234});
      step();
      i_push = 1'b0;
      check("call_w2", {o_busy, o_stk_addr, o_stk_wdata}, {1'b0, 16'h2346, 16'h005A});
      step();
      check("call_sp", o_soft_stack_pointer, 16'h2348);
   endtask : t_call

   // Exception save merges the status byte; return unwinds the frame.
   task automatic t_exc_ret;
      i_pc = 23'h7F0ABC;
      i_status_low_byte = 8'hC3;
      i_exception = 1'b1;
      step();
      i_exception = 1'b0;
      check("exc_w1", o_stk_wdata, 16'h0ABC);
      step();
      check("exc_w2", o_stk_wdata, 16'hC37F);
      i_return = 1'b1;
      step();
      i_return = 1'b0;
      check("ret_r1", {o_stk_re, o_stk_addr}, {1'b1, 16'h234A});
      step();
      check("ret_r2", {o_stk_re, o_stk_addr, o_soft_stack_pointer}, {1'b1, 32'h23482348});
   endtask : t_exc_ret

   // One operand request; the pointer is the register in i_src_reg, 7 the base.
   task automatic op(input logic f, m, input logic [2:0] md, input logic [15:0] fld, exp);
      {i_op_file, i_op_move, i_mode, i_op_field, i_base_reg} = {f, m, md, fld, 4'h7};
      i_op_req = 1'b1;
      step();
      i_op_req = 1'b0;
      check("op_valid", o_op_valid, 1'b1);
      check("op_base", o_base_operand_reg, 4'h7);
      check("op_dest", o_dest_reg, REG_ZERO);
      if (md != 3'h5 && md != 3'h4) check("op_addr", o_op_addr, exp);
      else check("op_lit", {o_op_is_lit, o_op_lit}, {1'b1, exp});
      step(3);
   endtask : op

   task automatic t_ops;
      i_src_reg = 4'h3;
      i_reg_wr = 1'b1;
      i_reg_waddr = 4'h3;
      i_reg_wdata = 16'h0400;
      step();
      i_reg_wr = 1'b0;
      step(2);
      op(1'b1, 1'b0, 3'h0, 16'hFFFF, 16'h1FFF);
      op(1'b0, 1'b1, 3'h0, 16'hFFFF, 16'hFFFF);
      op(1'b0, 1'b0, 3'h1, 16'h0000, 16'h0400);
      op(1'b0, 1'b0, 3'h3, 16'h0000, 16'h0400);
      op(1'b0, 1'b0, 3'h7, 16'h0000, 16'h0400);
      op(1'b0, 1'b0, 3'h6, 16'h0000, 16'h0402);
      op(1'b0, 1'b0, 3'h2, 16'h0000, 16'h0402);
      op(1'b0, 1'b0, 3'h1, 16'h0000, 16'h0400);
      op(1'b0, 1'b0, 3'h5, 16'h003F, 16'h001F);
      op(1'b0, 1'b0, 3'h4, 16'h07FF, 16'h03FF);
   endtask : t_ops

   // Frame and stack pointers as operand pointers, then a byte-step modify.
   task automatic t_frame;
      i_fp_wr = 1'b1;
      i_fp_wdata = 16'h3000;
      step();
      i_fp_wr = 1'b0;
      check("fp_write", o_frame_pointer_reg, 16'h3000);
      i_frame_pointer_active = 1'b1;
      i_src_reg = REG_FRAME;
      op(1'b0, 1'b0, 3'h3, 16'h0000, 16'h3000);
      check("fp_unpaged", o_op_unpaged, 1'b1);
      check("fp_modified", o_frame_pointer_reg, 16'h3002);
      i_frame_pointer_active = 1'b0;
      op(1'b0, 1'b0, 3'h1, 16'h0000, 16'h3002);
      check("fp_paged", o_op_unpaged, 1'b0);
      i_src_reg = REG_STACK;
      op(1'b0, 1'b0, 3'h3, 16'h0000, 16'h2348);
      check("sp_unpaged", o_op_unpaged, 1'b1);
      check("sp_modified", o_soft_stack_pointer, 16'h234A);
      // The file read lags one cycle, so the new index settles before the request.
      i_src_reg = 4'h3;
      i_byte_op = 1'b1;
      step();
      op(1'b0, 1'b0, 3'h3, 16'h0000, 16'h0400);
      op(1'b0, 1'b0, 3'h1, 16'h0000, 16'h0401);
      i_byte_op = 1'b0;
   endtask : t_frame

   // Mid-run reset brings the pointer back; a push follows at the first edge.
   task automatic t_reset;
      i_resetn = 1'b0;
      step(2);
      check("rst_sp", o_soft_stack_pointer, SP_RESET);
      check("rst_idle", {o_busy, o_stk_we, o_frame_pointer_reg}, 18'h00000);
      i_resetn = 1'b1;
      i_push = 1'b1;
      i_push_data = 16'h1234;
      step();
      i_push = 1'b0;
      check("rst_push", {o_stk_we, o_stk_addr, o_stk_wdata}, {1'b1, SP_RESET, 16'h1234});
      check("rst_push_sp", o_soft_stack_pointer, 16'h1002);
   endtask : t_reset

   // Main sequence: quiet inputs, eight cycles of reset, then each scenario.
   initial begin
      {i_sp_wr, i_fp_wr, i_frame_pointer_active, i_push, i_pop, i_call, i_exception} = '0;
      {i_return, i_op_req, i_op_file, i_op_move, i_byte_op, i_reg_wr, i_sp_wdata} = '0;
      {i_fp_wdata, i_push_data, i_op_field, i_reg_wdata, i_pc, i_status_low_byte} = '0;
      {i_base_reg, i_src_reg, i_reg_waddr, i_mode} = '0;
      step(8);
      i_resetn = 1'b1;
      check("reset_sp", o_soft_stack_pointer, SP_RESET);
      check("dest_reg", o_dest_reg, REG_ZERO);
      t_push_pop();
      t_sp_write();
      t_call();
      t_exc_ret();
      t_ops();
      t_frame();
      t_reset();
      results();
   end

   // Watchdog: the whole run needs about 90 cycles, so this is ample margin.
   initial begin
      repeat (3000) @(posedge i_sys_clk);
      failures++;
      results();
   end
endmodule : test_cpu_stack_and_operand_addressing
`default_nettype wire
